// ### relay_alarm_params.svh
`ifndef RELAY_ALARM_PARAMS_SVH
`define RELAY_ALARM_PARAMS_SVH

// Channel count, section count and APB address width.
`define RA_NUM_CHANNELS 16
`define RA_NUM_SECTIONS 4
`define RA_ADDR_W 12

// Register byte offsets; each channel owns two words at a stride of 8.
`define RA_CH_STRIDE 12'h008
`define RA_CH_CFG_OFS 12'h000
`define RA_CH_THR_OFS 12'h004
`define RA_CH_REGION_END 12'h080
`define RA_COIL_STATUS 12'h080
`define RA_ALARM_STATUS 12'h084
`define RA_PULSE_STATUS 12'h088

// Field positions in a channel configuration word.
`define RA_SEC_LSB 0
`define RA_SEC_W 4
`define RA_FUNC_LSB 8
`define RA_FUNC_W 4
`define RA_POL_BIT 12
`define RA_DELAY_LSB 16
`define RA_DELAY_W 16

// Reset values of the channel words.
`define RA_CFG_RESET 32'h0000_0000
`define RA_THR_RESET 32'h0000_0000

// Function codes.
`define RA_FUNC_OFF 4'h0
`define RA_FUNC_FLOW 4'h1
`define RA_FUNC_LEVEL 4'h2
`define RA_FUNC_PATHSUB 4'h3
`define RA_FUNC_FAIL 4'h4
`define RA_FUNC_SECVOL 4'h5
`define RA_FUNC_SUMFLOW 4'h6
`define RA_FUNC_SUMVOL 4'h7

// Totalizer pulse timing: width and gap are both this long.
`define RA_CLK_MHZ 100
`define RA_PULSE_MS 100
`define RA_PULSE_CYCLES (`RA_PULSE_MS * 1000 * `RA_CLK_MHZ)
`define RA_QUEUE_W 8

`endif

// ### relay_alarm_pkg.sv
package relay_alarm_pkg;

    // Results of one section (or of the section sum) per measurement cycle.
    typedef struct packed {
        logic signed [31:0] flow;
        logic signed [31:0] level;
        logic pathSub;
        logic pipeMode;
        logic fail;
        logic volInc;
    } section_meas_s;

    // Configuration of one relay channel.
    typedef struct packed {
        logic [3:0] sec;
        logic [3:0] func;
        logic pol;
        logic [15:0] delay;
        logic signed [31:0] thr;
    } chan_cfg_s;

    // Totalizer pulse sequencer states.
    typedef enum logic [1:0] {
        PULSE_IDLE,
        PULSE_ON,
        PULSE_GAP
    } pulse_state_e;

endpackage : relay_alarm_pkg

// ### relay_channel.sv
`timescale 1ns/1ps
`include "relay_alarm_params.svh"

module relay_channel
    import relay_alarm_pkg::*;
#(
    parameter int PULSE_CYCLES = `RA_PULSE_CYCLES,
    parameter int QUEUE_W = `RA_QUEUE_W
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Measurement cycle strobe and the data bound to this channel.
    input wire logic measStrobe,
    input wire section_meas_s secMeas,
    input wire section_meas_s sumMeas,
    // Channel configuration.
    input wire chan_cfg_s cfg,
    // Coil drive and state.
    output logic coil,
    output logic alarmActive,
    output logic pulsing
);

    localparam int PW = $clog2(PULSE_CYCLES + 1);
    localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYCLES - 1);

    logic [15:0] persist_reg;
    logic active_reg;
    logic coil_reg;
    logic [QUEUE_W-1:0] pending_reg;
    logic [PW-1:0] pulseCnt_reg;
    pulse_state_e state_reg;

    // Alarm conditions for each function code.
    wire logic flowHigh = $signed(secMeas.flow) > $signed(cfg.thr); // see [RQ4]
    wire logic levelHigh = $signed(secMeas.level) > $signed(cfg.thr); // see [RQ5]
    wire logic sumHigh = $signed(sumMeas.flow) > $signed(cfg.thr); // see [RQ10]
    wire logic subOn = secMeas.pathSub & secMeas.pipeMode; // see [RQ6]
    wire logic condNow =
        (cfg.func == `RA_FUNC_FLOW) ? flowHigh :
        (cfg.func == `RA_FUNC_LEVEL) ? levelHigh :
        (cfg.func == `RA_FUNC_PATHSUB) ? subOn :
        (cfg.func == `RA_FUNC_FAIL) ? secMeas.fail : // see [RQ7]
        (cfg.func == `RA_FUNC_SUMFLOW) ? sumHigh : 1'b0; // see [RQ17]
    wire logic funcUsed = (cfg.func != `RA_FUNC_OFF) &&
        (cfg.func <= `RA_FUNC_SUMVOL); // see [RQ3] [RQ17]

    // Totalizer increments and queue bookkeeping.
    wire logic isPulse = (cfg.func == `RA_FUNC_SECVOL) ||
        (cfg.func == `RA_FUNC_SUMVOL);
    wire logic volInc = (cfg.func == `RA_FUNC_SECVOL) ? secMeas.volInc :
        (cfg.func == `RA_FUNC_SUMVOL) ? sumMeas.volInc : 1'b0; // see [RQ8] [RQ11]
    wire logic take = (state_reg == PULSE_IDLE) && (pending_reg != '0);
    wire logic full = &pending_reg;
    wire logic [QUEUE_W-1:0] pendAdd = (volInc && !full) ?
        QUEUE_W'(1) : '0;
    wire logic [QUEUE_W-1:0] pendSub = take ? QUEUE_W'(1) : '0;
    wire logic pulseEnd = (pulseCnt_reg == PULSE_LAST);

    // Persistence counting: advance on strobe, restart when the alarm clears.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            persist_reg <= 16'h0000;
            active_reg <= 1'b0;
        end
        else if (!condNow)
        begin
            persist_reg <= 16'h0000; // see [RQ15]
            active_reg <= 1'b0; // see [RQ15]
        end
        else if (measStrobe)
        begin
            if (persist_reg >= cfg.delay)
                active_reg <= 1'b1; // see [RQ13] [RQ14]
            else
                persist_reg <= persist_reg + 16'h0001; // see [RQ17]
        end
    end

    // Pulse queue: an increment in the same cycle as a take is kept unless the queue is full.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pending_reg <= '0;
        else if (!isPulse)
            pending_reg <= '0;
        else
            pending_reg <= pending_reg + pendAdd - pendSub; // see [RQ18]
    end

    // Fixed-width pulse followed by an equal gap.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= PULSE_IDLE;
            pulseCnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                PULSE_IDLE:
                begin
                    pulseCnt_reg <= '0;
                    if (take)
                        state_reg <= PULSE_ON; // see [RQ18]
                end
                PULSE_ON:
                begin
                    pulseCnt_reg <= pulseEnd ? '0 : pulseCnt_reg + 1'b1;
                    if (pulseEnd)
                        state_reg <= PULSE_GAP;
                end
                PULSE_GAP:
                begin
                    pulseCnt_reg <= pulseEnd ? '0 : pulseCnt_reg + 1'b1;
                    if (pulseEnd)
                        state_reg <= PULSE_IDLE;
                end
                default:
                    state_reg <= PULSE_IDLE;
            endcase
        end
    end

    // Coil drive: operated state flipped by the polarity bit.
    wire logic operated = funcUsed &&
        (active_reg || (isPulse && state_reg == PULSE_ON)); // see [RQ3]
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            coil_reg <= 1'b0;
        else
            coil_reg <= operated ^ cfg.pol; // see [RQ16]
    end

    assign coil = coil_reg;
    assign alarmActive = active_reg;
    assign pulsing = (state_reg == PULSE_ON);

    property p_unused_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        (cfg.func == `RA_FUNC_OFF) ##1
            (cfg.func == `RA_FUNC_OFF && $stable(cfg.pol))
            |-> coil_reg == cfg.pol;
    endproperty
    a_unused_idle: assert property (p_unused_idle) // see [RQ3]
        else $error("Unused channel drove its coil.");

    property p_release;
        @(posedge sys_clk) disable iff (sys_rst)
        (active_reg && !condNow) |=> !active_reg;
    endproperty
    a_release: assert property (p_release) // see [RQ15]
        else $error("Alarm did not release at once.");

    property p_persist;
        @(posedge sys_clk) disable iff (sys_rst)
        (measStrobe && condNow && !active_reg && persist_reg < cfg.delay)
            |=> !active_reg;
    endproperty
    a_persist: assert property (p_persist) // see [RQ13]
        else $error("Alarm rose before the delay count elapsed.");

    property p_pulse_width;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(pulsing) |-> (pulseCnt_reg == '0) ##1 pulsing;
    endproperty
    a_pulse_width: assert property (p_pulse_width) // see [RQ18]
        else $error("Totalizer pulse was cut short.");

    property p_pulse_len;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(pulsing) |-> $past(pulseCnt_reg) == PULSE_LAST;
    endproperty
    a_pulse_len: assert property (p_pulse_len) // see [RQ18]
        else $error("Totalizer pulse length was wrong.");

endmodule : relay_channel

// ### relay_alarm_controller.sv
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "relay_alarm_params.svh"

// Operation
// [RQ1] Sixteen independent channels, each with binding, type, threshold, delay, polarity.
// [RQ2] Channel input comes from its bound section; binding zero selects sums.
// [RQ3] Type zero means unused; relay never operated.
// [RQ4] Type one operates when section flow exceeds threshold.
// [RQ5] Type two operates when section level exceeds threshold.
// [RQ6] Type three operates while path substitution is active, pipe mode only.
// [RQ7] Type four operates when the bound section reports failure.
// [RQ8] Type five emits totalizer pulses for the bound section volume.
// [RQ9] Software gives section pulse function to at most one channel per section.
// [RQ10] Type six operates when summed flow exceeds threshold.
// [RQ11] Type seven emits totalizer pulses for summed volume.
// [RQ12] Threshold is signed, covering at least minus to plus 99999.
// [RQ13] Threshold alarms operate after exceeding for the delay count of cycles.
// [RQ14] Failure and substitution alarms operate after the delay count from onset.
// [RQ15] Cleared alarm releases the relay at once and restarts the count.
// [RQ16] Polarity zero: idle de-energized; one: idle energized.
// [RQ17] Counting advances per measurement strobe; codes above seven are unused.
// [RQ18] One fixed-width pulse per volume increment; increments queue meanwhile.

module relay_alarm_controller
    import relay_alarm_pkg::*;
#(
    parameter int NCH = `RA_NUM_CHANNELS,
    parameter int NSEC = `RA_NUM_SECTIONS,
    parameter int PULSE_CYCLES = `RA_PULSE_CYCLES,
    parameter int QUEUE_W = `RA_QUEUE_W
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RA_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Flow computation results.
    input wire logic measStrobe,
    input wire section_meas_s secMeas [1:NSEC],
    input wire section_meas_s sumMeas,
    // Relay coil drives.
    output logic [NCH-1:0] relayCoil
);

    localparam int CW = $clog2(NCH);

    chan_cfg_s cfg_reg [NCH];
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [NCH-1:0] coilVec;
    logic [NCH-1:0] alarmVec;
    logic [NCH-1:0] pulseVec;
    section_meas_s selMeas [NCH];

    // Returns true when a word-aligned address falls inside the per-channel region.
    function automatic logic inChanRegion(
        input logic [`RA_ADDR_W-1:0] addr
    );
        inChanRegion = (addr < `RA_CH_REGION_END) && (addr[1:0] == 2'b00);
    endfunction : inChanRegion

    // Returns the channel addressed by a per-channel register access.
    function automatic logic [CW-1:0] chanOf(
        input logic [`RA_ADDR_W-1:0] addr
    );
        chanOf = addr[CW+2:3];
    endfunction : chanOf

    // Picks the bound section, or the section sums for binding zero.
    function automatic section_meas_s pickMeas(
        input logic [3:0] sec,
        input section_meas_s sums,
        input section_meas_s secs [1:NSEC]
    );
        pickMeas = '0;
        if (sec == 4'h0)
            pickMeas = sums;
        for (int s = 1; s <= NSEC; s++)
        begin
            if (sec == 4'(s))
                pickMeas = secs[s];
        end
    endfunction : pickMeas

    // Bus decode.
    wire logic setup = psel && !penable;
    wire logic access = psel && penable && pready_reg;
    wire logic wrAccess = access && pwrite;
    wire logic chanHit = inChanRegion(paddr);
    wire logic thrHit = (paddr[2] == 1'b1);
    wire logic [CW-1:0] chanIdx = chanOf(paddr);
    wire logic statusHit = (paddr == `RA_COIL_STATUS) ||
        (paddr == `RA_ALARM_STATUS) || (paddr == `RA_PULSE_STATUS);
    wire logic mapped = chanHit || (statusHit && !pwrite);

    // Read multiplexer for the per-channel words and the status words.
    wire chan_cfg_s rdCfg = cfg_reg[chanIdx];
    wire logic [31:0] cfgWord = {rdCfg.delay, 3'b000, rdCfg.pol,
        rdCfg.func, 4'h0, rdCfg.sec};
    wire logic [31:0] chanWord = thrHit ? 32'(rdCfg.thr) : cfgWord;
    wire logic [31:0] statusWord =
        (paddr == `RA_COIL_STATUS) ? 32'(relayCoil) :
        (paddr == `RA_ALARM_STATUS) ? 32'(alarmVec) :
        (paddr == `RA_PULSE_STATUS) ? 32'(pulseVec) : 32'h0000_0000;
    wire logic [31:0] rdWord = chanHit ? chanWord : statusWord;

    // Fields of a written configuration word.
    wire logic [3:0] wrSec = pwdata[`RA_SEC_LSB +: `RA_SEC_W];
    wire logic [3:0] wrFunc = pwdata[`RA_FUNC_LSB +: `RA_FUNC_W];
    wire logic wrPol = pwdata[`RA_POL_BIT];
    wire logic [15:0] wrDelay = pwdata[`RA_DELAY_LSB +: `RA_DELAY_W];

    // Answer one cycle after setup: zero wait states, error if unmapped.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= setup;
            prdata_reg <= (setup && !pwrite && mapped) ? rdWord
                : 32'h0000_0000;
            pslverr_reg <= setup && !mapped;
        end
    end

    // Channel configuration storage, one pair of words per channel.
    generate
        for (genvar c = 0; c < NCH; c++)
        begin : g_cfg
            wire logic hitMe = wrAccess && chanHit &&
                (chanIdx == CW'(c));
            always_ff @(posedge sys_clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    cfg_reg[c].sec <= 4'(`RA_CFG_RESET >> `RA_SEC_LSB);
                    cfg_reg[c].func <= 4'(`RA_CFG_RESET >> `RA_FUNC_LSB);
                    cfg_reg[c].pol <= 1'(`RA_CFG_RESET >> `RA_POL_BIT);
                    cfg_reg[c].delay <= 16'(`RA_CFG_RESET >> `RA_DELAY_LSB);
                    cfg_reg[c].thr <= `RA_THR_RESET; // see [RQ12]
                end
                else if (hitMe && thrHit)
                    cfg_reg[c].thr <= pwdata; // see [RQ12]
                else if (hitMe)
                begin
                    cfg_reg[c].sec <= wrSec; // see [RQ1]
                    cfg_reg[c].func <= wrFunc;
                    cfg_reg[c].pol <= wrPol;
                    cfg_reg[c].delay <= wrDelay;
                end
            end
        end
    endgenerate

    // One alarm and pulse engine per channel, fed by its bound section.
    generate
        for (genvar c = 0; c < NCH; c++)
        begin : g_chan
            assign selMeas[c] = pickMeas(cfg_reg[c].sec, sumMeas,
                secMeas); // see [RQ2]
            relay_channel #(
                .PULSE_CYCLES(PULSE_CYCLES),
                .QUEUE_W(QUEUE_W)
            ) u_chan (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .measStrobe(measStrobe), // see [RQ17]
                .secMeas(selMeas[c]),
                .sumMeas(sumMeas),
                .cfg(cfg_reg[c]),
                .coil(coilVec[c]), // see [RQ1]
                .alarmActive(alarmVec[c]),
                .pulsing(pulseVec[c])
            );
        end
    endgenerate

    // Outputs come straight from flip-flops.
    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign relayCoil = coilVec;

    property p_ready_after_setup;
        @(posedge sys_clk) disable iff (sys_rst)
        setup |=> pready_reg ##1 !pready_reg;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("APB answer not given one cycle after setup.");

    property p_unmapped_err;
        @(posedge sys_clk) disable iff (sys_rst)
        (setup && !mapped) |=> (pslverr_reg && prdata_reg == 32'h0);
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("Unmapped access not flagged.");

    property p_thr_write;
        @(posedge sys_clk) disable iff (sys_rst)
        (wrAccess && chanHit && thrHit)
            |=> $signed(cfg_reg[$past(chanIdx)].thr) == $signed($past(pwdata));
    endproperty
    a_thr_write: assert property (p_thr_write) // see [RQ12]
        else $error("Threshold write not stored.");

    property p_sum_binding;
        @(posedge sys_clk) disable iff (sys_rst)
        (cfg_reg[0].sec == 4'h0) |-> selMeas[0] == sumMeas;
    endproperty
    a_sum_binding: assert property (p_sum_binding) // see [RQ2]
        else $error("Binding zero did not select the sums.");

endmodule : relay_alarm_controller

// ### flow_meas_model.sv
`timescale 1ns/1ps
`include "relay_alarm_params.svh"

module flow_meas_model
    import relay_alarm_pkg::*;
(
    // Clock of the block.
    input wire logic sys_clk,
    // Results handed to the relay block.
    output logic measStrobe,
    output section_meas_s secMeas [1:`RA_NUM_SECTIONS],
    output section_meas_s sumMeas
);
    // All results start at zero with no strobe.
    initial
    begin
        measStrobe = 1'b0;
        sumMeas = '0;
        foreach (secMeas[i]) secMeas[i] = '0;
    end

    // Loads one section, or the sums when the index is zero.
    task set_sec(input int s, input logic [31:0] f, input logic [31:0] lv,
                 input logic ps, input logic pm, input logic fl);
        @(posedge sys_clk);
        if (s == 0) sumMeas <= {f, lv, ps, pm, fl, 1'b0};
        else secMeas[s] <= {f, lv, ps, pm, fl, 1'b0};
    endtask : set_sec

    // Gives n one-cycle strobes, each followed by a quiet cycle.
    task strobe(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            measStrobe <= 1'b1;
            @(posedge sys_clk);
            measStrobe <= 1'b0;
        end
    endtask : strobe

    // Signals one volume increment, a single-cycle pulse.
    task vol(input int s);
        @(posedge sys_clk);
        if (s == 0) sumMeas.volInc <= 1'b1;
        else secMeas[s].volInc <= 1'b1;
        @(posedge sys_clk);
        if (s == 0) sumMeas.volInc <= 1'b0;
        else secMeas[s].volInc <= 1'b0;
    endtask : vol
endmodule : flow_meas_model

// ### relay_alarm_controller_tb_top.sv
`timescale 1ns/1ps
`include "relay_alarm_params.svh"

module relay_alarm_controller_tb_top
    import relay_alarm_pkg::*;
;
    localparam int PC = 4;
    logic sys_clk;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic measStrobe;
    section_meas_s secMeas [1:`RA_NUM_SECTIONS];
    section_meas_s sumMeas;
    logic [15:0] relayCoil;
    logic [31:0] rdv;
    logic errv;
    int error_cnt = 0;
    int total_checks = 0;

    // Block under test with short totalizer pulses.
    relay_alarm_controller #(.PULSE_CYCLES(PC)) u_relay_alarm_controller (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .measStrobe(measStrobe), .secMeas(secMeas),
        .sumMeas(sumMeas), .relayCoil(relayCoil));

    // Source of the measurement results.
    flow_meas_model u_flow_meas_model (
        .sys_clk(sys_clk), .measStrobe(measStrobe), .secMeas(secMeas),
        .sumMeas(sumMeas));

    // Free-running 100 MHz clock.
    always #5 sys_clk = ~sys_clk;

    // Compares one value and counts it.
    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // One APB transfer; waits for pready, the watchdog bounds the wait.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reads a register and compares data and error flag.
    task rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0000_0000);
        check("prdata", rdv, exp);
        check("pslverr", {31'h0, errv}, {31'h0, e});
    endtask : rd

    // Packs a channel configuration word.
    function logic [31:0] cfg_word(input logic [3:0] s, input logic [3:0] f,
                                   input logic p, input logic [15:0] dl);
        return {dl, 3'h0, p, f, 4'h0, s};
    endfunction : cfg_word

    // Waits for the coil to follow an alarm change.
    task settle;
        repeat (3) @(posedge sys_clk);
    endtask : settle

    // Reset values, read back, and refused accesses.
    task t_regs;
        rd(12'h000, 32'h0000_0000, 1'b0);
        rd(12'h07C, 32'h0000_0000, 1'b0);
        check("coil", relayCoil, 16'h0000);
        apb(1'b1, 12'h078, cfg_word(4'h4, 4'h4, 1'b1, 16'hABCD));
        rd(12'h078, cfg_word(4'h4, 4'h4, 1'b1, 16'hABCD), 1'b0);
        settle();
        check("idle coil", relayCoil[15], 1'b1);
        rd(12'h08C, 32'h0000_0000, 1'b1);
        rd(12'h002, 32'h0000_0000, 1'b1);
        apb(1'b1, `RA_COIL_STATUS, 32'hFFFF_FFFF);
        check("status wr err", {31'h0, errv}, 32'h0000_0001);
    endtask : t_regs

    // Flow alarm with persistence, release and signed limits.
    task t_flow;
        apb(1'b1, 12'h000, cfg_word(4'h1, `RA_FUNC_FLOW, 1'b0, 16'h0002));
        apb(1'b1, 12'h004, 32'h0000_0064);
        u_flow_meas_model.set_sec(1, 32'h0000_0065, 32'h0, 0, 0, 0);
        u_flow_meas_model.strobe(2);
        settle();
        check("early", relayCoil[0], 1'b0);
        u_flow_meas_model.strobe(1);
        settle();
        check("flow op", relayCoil[0], 1'b1);
        rd(`RA_ALARM_STATUS, 32'h0000_0001, 1'b0);
        u_flow_meas_model.set_sec(1, 32'h0000_0064, 32'h0, 0, 0, 0);
        settle();
        check("release", relayCoil[0], 1'b0);
        u_flow_meas_model.set_sec(1, 32'h0000_0065, 32'h0, 0, 0, 0);
        u_flow_meas_model.strobe(1);
        settle();
        check("restart", relayCoil[0], 1'b0);
        apb(1'b1, 12'h000, cfg_word(4'h1, `RA_FUNC_FLOW, 1'b0, 16'h0000));
        // Threshold of minus 99999.
        apb(1'b1, 12'h004, 32'hFFFE_7961);
        u_flow_meas_model.set_sec(1, 32'hFFFE_7961, 32'h0, 0, 0, 0);
        u_flow_meas_model.strobe(1);
        settle();
        check("equal", relayCoil[0], 1'b0);
        u_flow_meas_model.set_sec(1, 32'hFFFE_7962, 32'h0, 0, 0, 0);
        u_flow_meas_model.strobe(1);
        settle();
        check("above", relayCoil[0], 1'b1);
    endtask : t_flow

    // Every alarm type, with bindings 2, 0 and 3, on channels 1 to 8, then delayed failures.
    task t_types;
        logic [3:0] ts [8];
        logic [3:0] tf [8];
        logic [7:0] pol;
        logic [7:0] op;
        ts = '{2, 2, 2, 2, 0, 2, 2, 3};
        tf = '{2, 3, 4, 6, 1, 0, 9, 1};
        // Bit k belongs to channel k + 1; op is the operated state.
        pol = 8'h44;
        op = 8'h1F;
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, 12'((k + 1) * 8), cfg_word(ts[k], tf[k], pol[k],
                16'h0000));
            apb(1'b1, 12'((k + 1) * 8 + 4), 32'h0000_0032);
        end
        u_flow_meas_model.set_sec(2, 32'h0000_1388, 32'h0000_003C, 1, 1, 1);
        u_flow_meas_model.set_sec(0, 32'h0000_07D0, 32'h0, 0, 0, 0);
        settle();
        check("idle", relayCoil[8:1], pol);
        u_flow_meas_model.strobe(1);
        settle();
        check("types", relayCoil[8:1], op ^ pol);
        u_flow_meas_model.set_sec(2, 32'h0000_1388, 32'h0000_003C, 1, 0, 1);
        settle();
        check("pipe only", relayCoil[2], 1'b0);
        // Section 4 failure with delay 1, sum failure with delay 0.
        apb(1'b1, 12'h058, cfg_word(4'h4, `RA_FUNC_FAIL, 1'b0, 16'h0001));
        apb(1'b1, 12'h060, cfg_word(4'h0, `RA_FUNC_FAIL, 1'b0, 16'h0000));
        u_flow_meas_model.set_sec(4, 32'h0000_0001, 32'h0000_0002, 1, 1, 1);
        u_flow_meas_model.set_sec(0, 32'h0000_07D0, 32'h0000_0003, 1, 1, 1);
        u_flow_meas_model.strobe(1);
        settle();
        check("fail delay", relayCoil[12:11], 2'b10);
        u_flow_meas_model.strobe(1);
        settle();
        check("fail after", relayCoil[11], 1'b1);
    endtask : t_types

    // Totalizer pulses for one section and for the sum.
    task t_pulses;
        int hi9;
        int lo10;
        int up9;
        logic prev;
        hi9 = 0;
        lo10 = 0;
        up9 = 0;
        prev = 1'b0;
        // One section pulse channel for section 3 only.
        apb(1'b1, 12'h048,
            cfg_word(4'h3, `RA_FUNC_SECVOL, 1'b0, 16'h0000));
        apb(1'b1, 12'h050, cfg_word(4'h0, `RA_FUNC_SUMVOL, 1'b1, 16'h0));
        // Let the new idle level reach the coil before counting.
        settle();
        fork
            begin
                u_flow_meas_model.vol(3);
                u_flow_meas_model.vol(3);
                u_flow_meas_model.vol(0);
            end
            repeat (40)
            begin
                @(posedge sys_clk);
                hi9 += relayCoil[9];
                lo10 += !relayCoil[10];
                up9 += (relayCoil[9] && !prev);
                prev = relayCoil[9];
            end
        join
        check("sec pulses", up9, 2);
        check("sec width", hi9, 2 * PC);
        check("sum width", lo10, PC);
    endtask : t_pulses

    // Drives inputs at time zero, resets, then runs every scenario.
    initial
    begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_flow();
        t_types();
        t_pulses();
        end_sim();
    end

    // Cuts a hang short well past the expected run length.
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        end_sim();
    end
endmodule : relay_alarm_controller_tb_top
